// ===== core/seic_ctrl.sv
// supply event interrupt controller: converter flags and top-level irq
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - step-down good and fail events set status bits 4 and 5.
// - writing 1 to a bit at 0x1D clears that status flag.
// - writing 1 to a bit at 0x1E enables that converter event interrupt.
// - writing 1 to a bit at 0x1F disables that converter event interrupt.
// - register 0x20 reads back the converter event enables, reset to 0.
// - writing 1 to a source bit at 0x30 unmasks that source.
// - writing 1 to bit 7 at 0x30 unmasks globally, restoring source bits.
// - writing 1 to a source bit at 0x31 masks that source.
// - writing 1 to bit 7 at 0x31 masks globally, keeping source bits.
// - the unmask register accumulates enable and disable writes, reset 0.
// - register 0x33 shows each source's pending request, reset to 0.
// - reading the pending register releases the interrupt output, unless a newly gated source arrives in the same cycle.
// - step-up overcurrent, good and fail events set 0x1C bits 0 to 2.
module seic_ctrl (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire seic_pkg::seic_reg_req_t reg_req_in,
  input wire seic_pkg::seic_conv_evt_t conv_evt_in,
  input wire seic_pkg::seic_src_req_t src_req_in,
  output logic [7:0] reg_rdata_out,
  output logic irq_out_n
);
  import seic_pkg::*;

  logic [7:0] conv_status_q;
  logic [7:0] conv_status_d;
  logic [7:0] conv_en_q;
  logic [7:0] conv_en_d;
  logic [7:0] top_unmask_q;
  logic [7:0] top_unmask_d;
  logic [7:0] top_pend_q;
  logic [7:0] top_pend_d;
  logic [7:0] gated_prev_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic irq_n_q;
  logic irq_n_d;

  wire logic [7:0] conv_set;
  wire logic [7:0] conv_clr;
  wire logic [7:0] conv_en_set;
  wire logic [7:0] conv_en_clr;
  wire logic [7:0] top_set;
  wire logic [7:0] top_clr;
  wire logic [7:0] conv_active;
  wire logic dc1_pend;
  wire logic dc2_pend;
  wire logic [7:0] gated;
  wire logic [7:0] gated_new;
  wire logic pend_rd;
  wire logic [7:0] rd_mux;

  // register port decode
  assign conv_set = seic_conv_bits(conv_evt_in);
  assign conv_clr = seic_wr_hit(reg_req_in, SEIC_ADDR_CONV_CLEAR) ?
                    reg_req_in.wdata : 8'h00;
  assign conv_en_set = seic_wr_hit(reg_req_in, SEIC_ADDR_CONV_EN_SET) ?
                       reg_req_in.wdata : 8'h00;
  assign conv_en_clr = seic_wr_hit(reg_req_in, SEIC_ADDR_CONV_EN_CLR) ?
                       reg_req_in.wdata : 8'h00;
  assign top_set = seic_wr_hit(reg_req_in, SEIC_ADDR_TOP_EN_SET) ?
                   reg_req_in.wdata : 8'h00;
  assign top_clr = seic_wr_hit(reg_req_in, SEIC_ADDR_TOP_EN_CLR) ?
                   reg_req_in.wdata : 8'h00;
  assign pend_rd = reg_req_in.rd && (reg_req_in.addr == SEIC_ADDR_TOP_PENDING);

  // an event in the clear cycle survives: set wins over clear
  assign conv_status_d = ((conv_status_q & ~conv_clr) | conv_set)
                         & SEIC_CONV_IMPL;
  assign conv_en_d = ((conv_en_q | conv_en_set) & ~conv_en_clr)
                     & SEIC_CONV_IMPL;
  // global bit and per-source bits are separate flops, so a global
  // mask leaves every individual setting intact for the next unmask
  assign top_unmask_d = ((top_unmask_q | top_set) & ~top_clr)
                        & SEIC_UNMASK_IMPL;

  // converter sources: any enabled flag makes the source pending
  assign conv_active = conv_status_q & conv_en_q;
  assign dc1_pend = |conv_active[SEIC_BIT_UP_FAIL:SEIC_BIT_UP_OC];
  assign dc2_pend = |conv_active[SEIC_BIT_DN_FAIL:SEIC_BIT_DN_GOOD];

  always_comb
  begin
    top_pend_d = SEIC_RST_TOP_PENDING;
    top_pend_d[SEIC_BIT_RTC] = src_req_in.rtc_source;
    top_pend_d[SEIC_BIT_PB] = src_req_in.push_button_source;
    top_pend_d[SEIC_BIT_PWR] = src_req_in.power_monitor_source;
    top_pend_d[SEIC_BIT_DC1] = dc1_pend;
    top_pend_d[SEIC_BIT_DC2] = dc2_pend;
  end

  // edge of the gated set: a level that stays pending after the read
  // must not reassert at once, only a newly gated source does
  assign gated = top_pend_q & top_unmask_q & SEIC_SRC_IMPL
                 & {8{top_unmask_q[SEIC_BIT_ALL]}};
  assign gated_new = gated & ~gated_prev_q;
  assign irq_n_d = (|gated_new) ? 1'b0 :
                   (pend_rd ? 1'b1 : irq_n_q);

  // read mux; write-only and unmapped addresses read zero
  assign rd_mux =
    (reg_req_in.addr == SEIC_ADDR_CONV_STATUS) ? conv_status_q :
    (reg_req_in.addr == SEIC_ADDR_CONV_EN_STATE) ? conv_en_q :
    (reg_req_in.addr == SEIC_ADDR_TOP_UNMASK) ? top_unmask_q :
    (reg_req_in.addr == SEIC_ADDR_TOP_PENDING) ? top_pend_q :
    8'h00;
  assign rdata_d = reg_req_in.rd ? rd_mux : rdata_q;

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      conv_status_q <= SEIC_RST_CONV_STATUS;
      conv_en_q <= SEIC_RST_CONV_EN;
      top_unmask_q <= SEIC_RST_TOP_UNMASK;
      top_pend_q <= SEIC_RST_TOP_PENDING;
      gated_prev_q <= 8'h00;
      rdata_q <= SEIC_RST_RDATA;
      irq_n_q <= 1'b1;
    end
    else
    begin
      conv_status_q <= conv_status_d;
      conv_en_q <= conv_en_d;
      top_unmask_q <= top_unmask_d;
      top_pend_q <= top_pend_d;
      gated_prev_q <= gated;
      rdata_q <= rdata_d;
      irq_n_q <= irq_n_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign irq_out_n = irq_n_q;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_step_down_set: assert property (
    conv_evt_in.step_down_good_flag |=>
      conv_status_q[SEIC_BIT_DN_GOOD] ##1 (conv_status_q[SEIC_BIT_DN_GOOD]
      || $past(conv_clr[SEIC_BIT_DN_GOOD])))
    else $error("step-down good flag not latched");

  a_step_up_set: assert property (
    conv_evt_in.step_up_overcurrent_flag |=> conv_status_q[SEIC_BIT_UP_OC])
    else $error("overcurrent flag not latched");

  a_status_clear: assert property (
    conv_clr[SEIC_BIT_UP_FAIL] && !conv_set[SEIC_BIT_UP_FAIL]
    |=> !conv_status_q[SEIC_BIT_UP_FAIL])
    else $error("status clear had no effect");

  a_conv_enable: assert property (
    conv_en_set[SEIC_BIT_UP_GOOD] |=> conv_en_q[SEIC_BIT_UP_GOOD])
    else $error("converter enable not set");

  a_conv_disable: assert property (
    conv_en_clr[SEIC_BIT_DN_FAIL] |=> !conv_en_q[SEIC_BIT_DN_FAIL])
    else $error("converter enable not cleared");

  a_en_state_read: assert property (
    reg_req_in.rd && reg_req_in.addr == SEIC_ADDR_CONV_EN_STATE
    |=> reg_rdata_out == $past(conv_en_q))
    else $error("enable state read mismatch");

  a_src_unmask: assert property (
    top_set[SEIC_BIT_DC1] |=> top_unmask_q[SEIC_BIT_DC1])
    else $error("source unmask not set");

  a_src_mask: assert property (
    top_clr[SEIC_BIT_DC1] |=> !top_unmask_q[SEIC_BIT_DC1])
    else $error("source mask not applied");

  a_global_restore: assert property (
    top_set == 8'h80 |=> top_unmask_q[SEIC_BIT_ALL]
      && top_unmask_q[5:0] == $past(top_unmask_q[5:0]))
    else $error("global unmask lost source settings");

  a_global_keep: assert property (
    top_clr == 8'h80 |=> !top_unmask_q[SEIC_BIT_ALL]
      && top_unmask_q[5:0] == $past(top_unmask_q[5:0]))
    else $error("global mask lost source settings");

  a_conv_pending: assert property (
    conv_active[SEIC_BIT_UP_OC] |=> top_pend_q[SEIC_BIT_DC1])
    else $error("step-up source not pending");

  a_irq_release: assert property (
    pend_rd && gated_new == 8'h00 |=> irq_out_n)
    else $error("pending read did not release irq");

  a_irq_raise: assert property (
    |gated_new |=> !irq_out_n ##1 (!irq_out_n || $past(pend_rd)))
    else $error("irq not asserted for new unmasked source");

  a_up_good_set: assert property (
    conv_evt_in.step_up_good_flag |=> conv_status_q[SEIC_BIT_UP_GOOD])
    else $error("step-up good flag not latched");

  a_up_fail_set: assert property (
    conv_evt_in.step_up_fail_flag |=> conv_status_q[SEIC_BIT_UP_FAIL])
    else $error("step-up fail flag not latched");

  a_down_fail_set: assert property (
    conv_evt_in.step_down_fail_flag |=> conv_status_q[SEIC_BIT_DN_FAIL])
    else $error("step-down fail flag not latched");

  a_status_hold: assert property (
    conv_status_q[SEIC_BIT_UP_OC] && !conv_clr[SEIC_BIT_UP_OC]
    |=> conv_status_q[SEIC_BIT_UP_OC])
    else $error("status flag lost without a clear");

  a_clear_race: assert property (
    conv_clr[SEIC_BIT_UP_OC] && conv_set[SEIC_BIT_UP_OC]
    |=> conv_status_q[SEIC_BIT_UP_OC])
    else $error("event in the clear cycle was lost");

  a_down_clear: assert property (
    conv_clr[SEIC_BIT_DN_FAIL] && !conv_set[SEIC_BIT_DN_FAIL]
    |=> !conv_status_q[SEIC_BIT_DN_FAIL])
    else $error("step-down fail flag not cleared");

  a_clear_read: assert property (
    reg_req_in.rd && reg_req_in.addr == SEIC_ADDR_CONV_CLEAR
    |=> reg_rdata_out == 8'h00)
    else $error("write-only register read not zero");

  a_status_read: assert property (
    reg_req_in.rd && reg_req_in.addr == SEIC_ADDR_CONV_STATUS
    |=> reg_rdata_out == $past(conv_status_q))
    else $error("status read mismatch");

  a_rdata_hold: assert property (
    !reg_req_in.rd |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");

  a_en_keep: assert property (
    conv_en_set == 8'h00 && conv_en_clr == 8'h00 |=> $stable(conv_en_q))
    else $error("converter enables moved without a write");

  a_down_enable: assert property (
    conv_en_set[SEIC_BIT_DN_GOOD] |=> conv_en_q[SEIC_BIT_DN_GOOD])
    else $error("step-down enable not set");

  a_oc_disable: assert property (
    conv_en_clr[SEIC_BIT_UP_OC] |=> !conv_en_q[SEIC_BIT_UP_OC])
    else $error("overcurrent enable not cleared");

  a_unmask_keep: assert property (
    top_set == 8'h00 && top_clr == 8'h00 |=> $stable(top_unmask_q))
    else $error("unmask state moved without a write");

  a_unmask_read: assert property (
    reg_req_in.rd && reg_req_in.addr == SEIC_ADDR_TOP_UNMASK
    |=> reg_rdata_out == $past(top_unmask_q))
    else $error("unmask state read mismatch");

  a_rtc_unmask: assert property (
    top_set[SEIC_BIT_RTC] |=> top_unmask_q[SEIC_BIT_RTC])
    else $error("calendar source unmask not set");

  a_pend_read: assert property (
    reg_req_in.rd && reg_req_in.addr == SEIC_ADDR_TOP_PENDING
    |=> reg_rdata_out == $past(top_pend_q))
    else $error("pending read mismatch");

  a_src_pending: assert property (
    1'b1 |=> top_pend_q[SEIC_BIT_PWR]
      == $past(src_req_in.power_monitor_source))
    else $error("power monitor pending mismatch");

  a_down_pending: assert property (
    conv_active[SEIC_BIT_DN_FAIL] |=> top_pend_q[SEIC_BIT_DC2])
    else $error("step-down source not pending");

  a_none_pending: assert property (
    conv_active == 8'h00 |=> !top_pend_q[SEIC_BIT_DC1]
      && !top_pend_q[SEIC_BIT_DC2])
    else $error("converter source pending without a flag");

  a_irq_masked: assert property (
    !top_unmask_q[SEIC_BIT_ALL] && irq_out_n |=> irq_out_n)
    else $error("irq asserted while globally masked");

  a_irq_hold: assert property (
    !irq_out_n && !pend_rd |=> !irq_out_n)
    else $error("irq released without a pending read");

  a_irq_quiet: assert property (
    irq_out_n && gated_new == 8'h00 |=> irq_out_n)
    else $error("irq asserted without a new source");

  c_conv_irq: cover property (
    conv_evt_in.step_up_fail_flag ##[1:4] !irq_out_n);
  c_global_cycle: cover property (
    top_clr == 8'h80 ##[1:20] top_set == 8'h80);
  c_read_release: cover property (!irq_out_n && pend_rd ##1 irq_out_n);
  c_clear_race: cover property (conv_clr[0] && conv_set[0]);
  c_src_irq: cover property (src_req_in.rtc_source ##[1:4] !irq_out_n);

endmodule : seic_ctrl

`default_nettype wire

// ===== core/seic_pkg.sv
// package: register map, field layout and carriers of the supply interrupt ctrl
`default_nettype none
package seic_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] SEIC_ADDR_CONV_STATUS = 8'h1c;
  localparam logic [7:0] SEIC_ADDR_CONV_CLEAR = 8'h1d;
  localparam logic [7:0] SEIC_ADDR_CONV_EN_SET = 8'h1e;
  localparam logic [7:0] SEIC_ADDR_CONV_EN_CLR = 8'h1f;
  localparam logic [7:0] SEIC_ADDR_CONV_EN_STATE = 8'h20;
  localparam logic [7:0] SEIC_ADDR_TOP_EN_SET = 8'h30;
  localparam logic [7:0] SEIC_ADDR_TOP_EN_CLR = 8'h31;
  localparam logic [7:0] SEIC_ADDR_TOP_UNMASK = 8'h32;
  localparam logic [7:0] SEIC_ADDR_TOP_PENDING = 8'h33;

  // converter flag positions
  localparam int SEIC_BIT_UP_OC = 0;
  localparam int SEIC_BIT_UP_GOOD = 1;
  localparam int SEIC_BIT_UP_FAIL = 2;
  localparam int SEIC_BIT_DN_GOOD = 4;
  localparam int SEIC_BIT_DN_FAIL = 5;

  // top-level source positions
  localparam int SEIC_BIT_RTC = 0;
  localparam int SEIC_BIT_PB = 1;
  localparam int SEIC_BIT_PWR = 2;
  localparam int SEIC_BIT_DC1 = 4;
  localparam int SEIC_BIT_DC2 = 5;
  localparam int SEIC_BIT_ALL = 7;

  // implemented bits and reset values
  localparam logic [7:0] SEIC_CONV_IMPL = 8'h37;
  localparam logic [7:0] SEIC_SRC_IMPL = 8'h37;
  localparam logic [7:0] SEIC_UNMASK_IMPL = 8'hb7;
  localparam logic [7:0] SEIC_RST_CONV_STATUS = 8'h00;
  localparam logic [7:0] SEIC_RST_CONV_EN = 8'h00;
  localparam logic [7:0] SEIC_RST_TOP_UNMASK = 8'h00;
  localparam logic [7:0] SEIC_RST_TOP_PENDING = 8'h00;
  localparam logic [7:0] SEIC_RST_RDATA = 8'h00;

  // host access gap: three slow-clock periods, kept by the host
  localparam int SEIC_GAP_PERIODS = 3;
  localparam int SEIC_SLOW_CLK_HZ = 15000;
  localparam int SEIC_SYS_CLK_HZ = 250000000;
  // multiply first: the clock ratio is not whole and would truncate
  localparam int SEIC_GAP_CYCLES =
    ((SEIC_GAP_PERIODS * SEIC_SYS_CLK_HZ) / SEIC_SLOW_CLK_HZ) + 1;

  typedef struct packed {
    logic step_down_fail_flag;
    logic step_down_good_flag;
    logic step_up_fail_flag;
    logic step_up_good_flag;
    logic step_up_overcurrent_flag;
  } seic_conv_evt_t;

  typedef struct packed {
    logic power_monitor_source;
    logic push_button_source;
    logic rtc_source;
  } seic_src_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } seic_reg_req_t;

  // place converter events at their register bit positions
  function automatic logic [7:0] seic_conv_bits(input seic_conv_evt_t e);
    logic [7:0] b;
    b = 8'h00;
    b[SEIC_BIT_UP_OC] = e.step_up_overcurrent_flag;
    b[SEIC_BIT_UP_GOOD] = e.step_up_good_flag;
    b[SEIC_BIT_UP_FAIL] = e.step_up_fail_flag;
    b[SEIC_BIT_DN_GOOD] = e.step_down_good_flag;
    b[SEIC_BIT_DN_FAIL] = e.step_down_fail_flag;
    return b;
  endfunction : seic_conv_bits

  // write strobe for one register address
  function automatic logic seic_wr_hit(input seic_reg_req_t r,
                                       input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction : seic_wr_hit

endpackage : seic_pkg

`default_nettype wire

// ===== tb/seic_host_model.sv
// host model: single-cycle register accesses with the access gap
`timescale 1ns/1ns
`default_nettype none
module seic_host_model #(
  parameter int GAP = 4
) (
  input wire logic clk_in,
  output var seic_pkg::seic_reg_req_t req_out
);
  import seic_pkg::*;
  initial req_out = '0;
  // requests change at the falling edge, held over one rising edge
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
    @(negedge clk_in);
    req_out = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk_in);
    // released lines do not keep the old value
    req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    // gap shortened from the slow-clock figure to keep the run short
    repeat (GAP) @(negedge clk_in);
  endtask : access
endmodule : seic_host_model
`default_nettype wire

// ===== tb/supply_event_interrupt_ctrl_test.sv
// testbench: registers and interrupt output of the supply event controller
`timescale 1ns/1ns
`default_nettype none
module supply_event_interrupt_ctrl_test;
  import seic_pkg::*;
  logic sys_clk_in;
  logic nrst_in;
  seic_reg_req_t req;
  seic_conv_evt_t evt;
  seic_src_req_t src;
  logic [7:0] rdata;
  logic irq_n;
  logic rd_seen;
  logic [7:0] expq[$];
  logic [31:0] seed;
  logic [7:0] st, ce, um, r;
  int fails;
  int compares;
  seic_ctrl dut_u (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .reg_req_in(req),
    .conv_evt_in(evt),
    .src_req_in(src),
    .reg_rdata_out(rdata),
    .irq_out_n(irq_n)
  );
  seic_host_model #(.GAP(4)) host_u (.clk_in(sys_clk_in), .req_out(req));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h0400_0007 : 32'h0000_0000);
  endfunction : lfsr
  function automatic logic [7:0] pend();
    return {2'b00, |(st & ce & 8'h30), |(st & ce & 8'h07), 1'b0, src};
  endfunction : pend
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic chk_irq(input logic e);
    check({7'h00, irq_n}, {7'h00, e});
  endtask : chk_irq
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.access(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    host_u.access(1'b0, a, 8'h00);
  endtask : rd
  task automatic pulse(input logic [4:0] e);
    @(negedge sys_clk_in);
    evt = e;
    @(negedge sys_clk_in);
    evt = '0;
    st = st | {2'b00, e[4:3], 1'b0, e[2:0]};
  endtask : pulse
  task automatic end_of_test();
    $display("TB: compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // read data is registered on the edge that took the read and checked at the next falling edge
  always @(posedge sys_clk_in) rd_seen <= req.rd;
  always @(negedge sys_clk_in)
  begin
    if (rd_seen && expq.size() > 0)
      check(rdata, expq.pop_front());
  end
  initial
  begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    #20000;
    fails++;
    end_of_test();
  end
  initial
  begin
    nrst_in = 1'b0;
    evt = '0;
    src = '0;
    fails = 0;
    compares = 0;
    st = 8'h00;
    ce = 8'h00;
    um = 8'h00;
    seed = 32'h53d8_3182;
    repeat (4) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    chk_irq(1'b1);
    rd(SEIC_ADDR_CONV_EN_STATE, 8'h00);
    rd(SEIC_ADDR_TOP_UNMASK, 8'h00);
    rd(SEIC_ADDR_TOP_PENDING, 8'h00);
    rd(SEIC_ADDR_CONV_STATUS, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    rd(SEIC_ADDR_CONV_CLEAR, 8'h00);
    $display("TB: reset values done");
    repeat (3)
    begin
      seed = lfsr(seed);
      r = seed[7:0] & SEIC_CONV_IMPL;
      wr(SEIC_ADDR_CONV_EN_SET, seed[7:0]);
      ce = ce | r;
      rd(SEIC_ADDR_CONV_EN_STATE, ce);
      wr(SEIC_ADDR_CONV_EN_CLR, seed[15:8]);
      ce = ce & ~seed[15:8];
      rd(SEIC_ADDR_CONV_EN_STATE, ce);
    end
    wr(SEIC_ADDR_CONV_EN_SET, SEIC_CONV_IMPL);
    ce = SEIC_CONV_IMPL;
    wr(SEIC_ADDR_CONV_EN_SET, 8'h00);
    rd(SEIC_ADDR_CONV_EN_STATE, ce);
    $display("TB: converter enables done");
    for (int i = 0; i < 5; i++)
      pulse(5'b00001 << i);
    rd(SEIC_ADDR_CONV_STATUS, st);
    wr(SEIC_ADDR_CONV_CLEAR, 8'h11);
    st = st & ~8'h11;
    rd(SEIC_ADDR_CONV_STATUS, st);
    wr(SEIC_ADDR_CONV_CLEAR, 8'h00);
    rd(SEIC_ADDR_CONV_STATUS, st);
    // event and clear in one cycle: the event must survive
    fork
      pulse(5'b00001);
      wr(SEIC_ADDR_CONV_CLEAR, 8'h01);
    join
    rd(SEIC_ADDR_CONV_STATUS, st);
    rd(SEIC_ADDR_TOP_PENDING, pend());
    chk_irq(1'b1);
    $display("TB: converter flags done");
    wr(SEIC_ADDR_TOP_EN_SET, 8'h30);
    um = 8'h30;
    rd(SEIC_ADDR_TOP_UNMASK, um);
    chk_irq(1'b1);
    wr(SEIC_ADDR_TOP_EN_SET, 8'h80);
    um = 8'hb0;
    chk_irq(1'b0);
    rd(SEIC_ADDR_TOP_UNMASK, um);
    chk_irq(1'b0);
    rd(SEIC_ADDR_TOP_PENDING, pend());
    chk_irq(1'b1);
    wr(SEIC_ADDR_TOP_EN_CLR, 8'h80);
    um = 8'h30;
    rd(SEIC_ADDR_TOP_UNMASK, um);
    wr(SEIC_ADDR_TOP_EN_CLR, 8'h10);
    wr(SEIC_ADDR_TOP_EN_SET, 8'h80);
    um = 8'ha0;
    rd(SEIC_ADDR_TOP_UNMASK, um);
    chk_irq(1'b0);
    rd(SEIC_ADDR_TOP_PENDING, pend());
    chk_irq(1'b1);
    $display("TB: top mask done");
    @(negedge sys_clk_in);
    src = 3'b101;
    wr(SEIC_ADDR_TOP_EN_SET, 8'h07);
    chk_irq(1'b0);
    rd(SEIC_ADDR_TOP_PENDING, pend());
    chk_irq(1'b1);
    @(negedge sys_clk_in);
    src = 3'b000;
    wr(SEIC_ADDR_CONV_CLEAR, 8'h37);
    st = 8'h00;
    rd(SEIC_ADDR_TOP_PENDING, pend());
    wr(SEIC_ADDR_CONV_EN_CLR, 8'h37);
    ce = 8'h00;
    rd(SEIC_ADDR_CONV_EN_STATE, ce);
    $display("TB: sources done");
    repeat (2) @(negedge sys_clk_in);
    end_of_test();
  end
endmodule : supply_event_interrupt_ctrl_test
`default_nettype wire
